/* pkg/led_pkg.sv */
// package: widths, reset values, status layout and pin idle levels for the led sink shift/latch block
// assumes: one system clock; all serial pins arrive asynchronously
package led_pkg;
    localparam int CHANNELS = 16;
    localparam int SYNC_STAGES = 2;
    localparam logic [15:0] LATCH_RESET = 16'h0000;
    localparam logic [15:0] SHIFT_RESET = 16'h0000;
    localparam logic [15:0] STATUS_ALL_ONES = 16'hFFFF;
    // synchroniser reset image {blank, latch, data, shift}: blank idles high
    localparam logic [3:0] PIN_IDLE = 4'h8;
    localparam int CLK_PERIOD_NS = 100;
endpackage

/* pkg/pin_edge_if.sv */
// interface: synchronised pin levels and their rising edges
// assumes: driven by pin_sync, read by the main module on clk_sys
`timescale 1ns/1ps
interface pin_edge_if;
    logic shiftRise;
    logic latchRise;
    logic blankRise;
    logic blankLevel;
    logic dataLevel;
    modport producer (output shiftRise, latchRise, blankRise, blankLevel, dataLevel);
    modport consumer (input shiftRise, latchRise, blankRise, blankLevel, dataLevel);
endinterface

/* rtl/pin_sync.sv */
// module: two-flop synchronisers and edge detectors for the serial pins
// assumes: pins change slower than clk_sys (link clock period 800 ns)
`timescale 1ns/1ps
module pin_sync (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic shiftClock,
    input wire logic serial_in,
    input wire logic latch_pulse,
    input wire logic blank,
    pin_edge_if.producer edges
);
    logic [3:0] stage1;
    logic [3:0] stage2;
    logic [3:0] stage3;
    logic [3:0] next_stage1;
    logic [3:0] next_stage2;
    logic [3:0] next_stage3;

    // first stage feeds only the second; third stage holds the prior value for edges
    always_comb begin
        next_stage1 = {blank, latch_pulse, serial_in, shiftClock};
        next_stage2 = stage1;
        next_stage3 = stage2;
    end

    // reset to the pins' idle levels so release shows no false blank rise
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            stage1 <= led_pkg::PIN_IDLE;
            stage2 <= led_pkg::PIN_IDLE;
            stage3 <= led_pkg::PIN_IDLE;
        end else begin
            stage1 <= next_stage1;
            stage2 <= next_stage2;
            stage3 <= next_stage3;
        end
    end

    // data sampled from stage3 so it is the level at the clock edge, aligned with shiftRise
    assign edges.shiftRise = stage2[0] & ~stage3[0];
    assign edges.dataLevel = stage3[1];
    assign edges.latchRise = stage2[2] & ~stage3[2];
    assign edges.blankRise = stage2[3] & ~stage3[3];
    assign edges.blankLevel = stage2[3];
endmodule // pin_sync

/* rtl/led_shift_latch.sv */
// module: serial on/off control path of a 16-channel led sink driver
// assumes: pins are asynchronous to clk_sys and much slower than it
`timescale 1ns/1ps
module led_shift_latch #(
    parameter int CHANNELS = led_pkg::CHANNELS
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic shiftClock,
    input wire logic serial_in,
    input wire logic latch_pulse,
    input wire logic blank,
    input wire logic [CHANNELS-1:0] open_led_flag,
    input wire logic thermal_warning_flag,
    output logic [CHANNELS-1:0] sink_output,
    output logic serial_out
);
    pin_edge_if edges ();
    logic [CHANNELS-1:0] shiftReg;
    logic [CHANNELS-1:0] onLatch;
    logic [CHANNELS-1:0] status_capture;
    logic [CHANNELS-1:0] next_shiftReg;
    logic [CHANNELS-1:0] next_onLatch;
    logic [CHANNELS-1:0] next_status_capture;
    logic [CHANNELS-1:0] openSync1;
    logic [CHANNELS-1:0] openSync2;
    logic thermSync1;
    logic thermSync2;
    // next values of the status synchronisers
    logic [CHANNELS-1:0] next_openSync1;
    logic [CHANNELS-1:0] next_openSync2;
    logic next_thermSync1;
    logic next_thermSync2;
    logic [CHANNELS-1:0] sinkReg;
    logic [CHANNELS-1:0] next_sinkReg;

    pin_sync i_pin_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .shiftClock(shiftClock),
        .serial_in(serial_in),
        .latch_pulse(latch_pulse),
        .blank(blank),
        .edges(edges)
    );

    // status sense lines are analog-side levels, so they are synchronised too
    // bits cross one by one: a flag moving just as blank rises lands in this
    // capture or the next one, which a slow level flag tolerates
    always_comb begin
        next_openSync1 = open_led_flag;
        next_openSync2 = openSync1;
        next_thermSync1 = thermal_warning_flag;
        next_thermSync2 = thermSync1;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            openSync1 <= '0;
            openSync2 <= '0;
            thermSync1 <= 1'h0;
            thermSync2 <= 1'h0;
        end else begin
            openSync1 <= next_openSync1;
            openSync2 <= next_openSync2;
            thermSync1 <= next_thermSync1;
            thermSync2 <= next_thermSync2;
        end
    end

    // status word: a thermal warning overrides every open-led bit
    function automatic logic [CHANNELS-1:0] statusWord(
        input logic [CHANNELS-1:0] openBits,
        input logic therm
    );
        statusWord = therm ? {CHANNELS{1'h1}} : openBits;
    endfunction

    // next state of shift register, latch and status latch
    // latch edge beats a coincident shift edge: the device forbids shifting that close anyway
    always_comb begin
        next_shiftReg = shiftReg;
        next_onLatch = onLatch;
        next_status_capture = status_capture;
        if (edges.latchRise) begin
            next_onLatch = shiftReg;
            next_shiftReg = status_capture;
        end else if (edges.shiftRise) begin
            next_shiftReg = {shiftReg[CHANNELS-2:0], edges.dataLevel};
        end
        if (edges.blankRise) begin
            next_status_capture = statusWord(openSync2, thermSync2);
        end
    end

    // reset gives a deterministic start in simulation; the real part powers up random
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            shiftReg <= led_pkg::SHIFT_RESET;
            onLatch <= led_pkg::LATCH_RESET;
            status_capture <= '0;
        end else begin
            shiftReg <= next_shiftReg;
            onLatch <= next_onLatch;
            status_capture <= next_status_capture;
        end
    end

    // output stage: blank gates the latch on the next clk_sys edge, whatever the shift side does
    always_comb begin
        next_sinkReg = edges.blankLevel ? '0 : onLatch;
    end

    // registered so channel enables never glitch while latch and blank move together
    // reset keeps the sinks off until the controller has loaded a word
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sinkReg <= '0;
        end else begin
            sinkReg <= next_sinkReg;
        end
    end

    assign sink_output = sinkReg;
    assign serial_out = shiftReg[CHANNELS-1];

    // assertions
    sequence latchEdge;
        edges.latchRise;
    endsequence
    sequence shiftOnly;
        edges.shiftRise && !edges.latchRise;
    endsequence

    AST_BLANK_OFF: assert property (@(posedge clk_sys) disable iff (rst)
        edges.blankLevel |=> (sink_output == '0))
        else $error("outputs on while blanked");
    AST_FOLLOW_LATCH: assert property (@(posedge clk_sys) disable iff (rst)
        !edges.blankLevel |=> (sink_output == $past(onLatch)))
        else $error("outputs do not follow latch");
    AST_SHIFT_LSB: assert property (@(posedge clk_sys) disable iff (rst)
        shiftOnly |=> (shiftReg[0] == $past(edges.dataLevel)))
        else $error("lsb not loaded from serial input");
    AST_SHIFT_MSB: assert property (@(posedge clk_sys) disable iff (rst)
        shiftOnly |=> (shiftReg[CHANNELS-1:1] == $past(shiftReg[CHANNELS-2:0])))
        else $error("shift toward msb failed");
    AST_SERIAL_OUT_STABLE: assert property (@(posedge clk_sys) disable iff (rst)
        (!edges.shiftRise && !edges.latchRise) |=> $stable(serial_out))
        else $error("serial output changed without shift edge");
    AST_LATCH_COPY: assert property (@(posedge clk_sys) disable iff (rst)
        latchEdge |=> (onLatch == $past(shiftReg)))
        else $error("latch did not copy shift register");
    AST_STATUS_LOAD: assert property (@(posedge clk_sys) disable iff (rst)
        latchEdge |=> (shiftReg == $past(status_capture)))
        else $error("status not loaded on latch");
    AST_STATUS_HOLD: assert property (@(posedge clk_sys) disable iff (rst)
        !edges.blankRise |=> $stable(status_capture))
        else $error("status latch changed without blank rise");
    AST_THERMAL_ALL: assert property (@(posedge clk_sys) disable iff (rst)
        (edges.blankRise && thermSync2) |=> (status_capture == led_pkg::STATUS_ALL_ONES))
        else $error("thermal warning did not set all bits");
    AST_MSB_OUT: assert property (@(posedge clk_sys) disable iff (rst)
        shiftOnly |=> (serial_out == $past(shiftReg[CHANNELS-2])))
        else $error("serial output not msb");

    // steps that span more than one edge, kept as named pieces
    // blankOnly leaves out coincident shift and latch edges, which move state anyway
    sequence latchThenShow;
        edges.latchRise ##1 !edges.blankLevel;
    endsequence
    sequence blankOnly;
        edges.blankRise && !edges.shiftRise && !edges.latchRise;
    endsequence

    // nothing moves the shift register without a shift or latch edge, or the latch without a latch edge
    AST_SHIFT_HOLD: assert property (@(posedge clk_sys) disable iff (rst)
        (!edges.shiftRise && !edges.latchRise) |=> $stable(shiftReg))
        else $error("shift register moved without an edge");
    AST_LATCH_HOLD: assert property (@(posedge clk_sys) disable iff (rst)
        !edges.latchRise |=> $stable(onLatch))
        else $error("latch moved without an edge");

    // latched word reaches the pins two edges after the latch pulse when unblanked
    AST_LATCH_SHOW: assert property (@(posedge clk_sys) disable iff (rst)
        latchThenShow |=> (sink_output == $past(shiftReg, 2)))
        else $error("latched word not on outputs");
    // after a latch the serial output shows the status msb at once
    AST_STATUS_MSB: assert property (@(posedge clk_sys) disable iff (rst)
        latchEdge |=> (serial_out == $past(status_capture[CHANNELS-1])))
        else $error("status msb not on serial output");
    AST_STATUS_OPEN: assert property (@(posedge clk_sys) disable iff (rst)
        (edges.blankRise && !thermSync2) |=> (status_capture == $past(openSync2)))
        else $error("open flags not captured on blank rise");

    // blanking must not disturb the shift path or the latch
    AST_BLANK_KEEPS: assert property (@(posedge clk_sys) disable iff (rst)
        blankOnly |=> ($stable(shiftReg) && $stable(onLatch)))
        else $error("blank rise disturbed shift register or latch");
    AST_SHIFT_BLANKED: assert property (@(posedge clk_sys) disable iff (rst)
        (edges.blankLevel && edges.shiftRise && !edges.latchRise)
        |=> (shiftReg[0] == $past(edges.dataLevel)))
        else $error("shift stalled while blanked");
    AST_LATCH_BLANKED: assert property (@(posedge clk_sys) disable iff (rst)
        (edges.blankLevel && edges.latchRise) |=> (onLatch == $past(shiftReg)))
        else $error("latch stalled while blanked");
endmodule // led_shift_latch

/* sim/led_ctrl_model.sv */
// display controller model driving the serial pins
// assumes clk_sys of 100 ns; link clock period of 800 ns
`timescale 1ns/1ps
module led_ctrl_model (
    input wire logic clk_sys,
    input wire logic serial_out,
    output logic shiftClock = 1'h0,
    output logic serial_in = 1'h0,
    output logic latch_pulse = 1'h0,
    output logic blank = 1'h1
);
    // n half link periods; pins move just after a clk_sys edge
    task automatic half(input int n);
        repeat (n * 4) @(posedge clk_sys);
        #1;
    endtask
    // msb first; serial_out is sampled before each rise, so a chain reads back
    task automatic shiftWord(input logic [15:0] w, output logic [15:0] seen);
        for (int i = 15; i >= 0; i--) begin
            serial_in = w[i];
            half(1);
            seen[i] = serial_out;
            shiftClock = 1'h1;
            half(1);
            shiftClock = 1'h0;
        end
    endtask
    // one pulse per update; the gap after it is well over 100 ns
    task automatic latchOnce();
        latch_pulse = 1'h1;
        half(1);
        latch_pulse = 1'h0;
        half(1);
    endtask
    task automatic setBlank(input logic level);
        blank = level;
        half(2);
    endtask
endmodule // led_ctrl_model

/* sim/led_shift_latch_tb_top.sv */
// self-checking bench for the led sink shift/latch block
// assumes led_ctrl_model drives the serial pins
`timescale 1ns/1ps
module led_shift_latch_tb_top;
    logic clkSys = 1'h0;
    logic rst = 1'h1;
    logic thermal = 1'h0;
    logic [15:0] openFlags = 16'h0000;
    logic shiftClock, serialIn, latchPulse, blank, serialOut;
    logic [15:0] sinkOut, seen;
    int errTotal = 0;
    int compares = 0;
    int cycles = 0;
    initial forever #50 clkSys = ~clkSys;
    led_shift_latch i_led_shift_latch (.clk_sys(clkSys), .rst(rst), .shiftClock(shiftClock),
        .serial_in(serialIn), .latch_pulse(latchPulse), .blank(blank),
        .open_led_flag(openFlags), .thermal_warning_flag(thermal),
        .sink_output(sinkOut), .serial_out(serialOut));
    led_ctrl_model i_led_ctrl_model (.clk_sys(clkSys), .serial_out(serialOut),
        .shiftClock(shiftClock), .serial_in(serialIn), .latch_pulse(latchPulse),
        .blank(blank));
    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            errTotal++;
            $display("[ERR] %0t %s: got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic stopTest();
        if (errTotal == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // cut a hang short; the run needs about 710 cycles
    always @(posedge clkSys) begin
        cycles++;
        if (cycles == 5000) begin
            errTotal++;
            $display("[ERR] %0t timeout", $time);
            stopTest();
        end
    end
    // two words back to back: the first leaves on serial_out, the second drives
    task automatic chainAndDrive();
        i_led_ctrl_model.shiftWord(16'h5A3C, seen);
        i_led_ctrl_model.shiftWord(16'hA5C3, seen);
        check(seen, 16'h5A3C, "chain");
        i_led_ctrl_model.latchOnce();
        i_led_ctrl_model.setBlank(1'h0);
        check(sinkOut, 16'hA5C3, "outputs");
    endtask
    // flags change after the blank rise: the captured copy must not follow
    task automatic statusRead();
        openFlags = 16'h1234;
        i_led_ctrl_model.setBlank(1'h1);
        check(sinkOut, 16'h0000, "blanked");
        openFlags = 16'h4321;
        i_led_ctrl_model.shiftWord(16'h00F0, seen);
        i_led_ctrl_model.latchOnce();
        check(sinkOut, 16'h0000, "still blanked");
        i_led_ctrl_model.setBlank(1'h0);
        check(sinkOut, 16'h00F0, "latched while blanked");
        i_led_ctrl_model.shiftWord(16'h0000, seen);
        check(seen, 16'h1234, "status");
        check(sinkOut, 16'h00F0, "latch kept");
    endtask
    // thermal warning reads back as every open flag set
    task automatic thermalRead();
        openFlags = 16'h0000;
        thermal = 1'h1;
        i_led_ctrl_model.setBlank(1'h1);
        i_led_ctrl_model.latchOnce();
        i_led_ctrl_model.shiftWord(16'h0000, seen);
        check(seen, 16'hFFFF, "thermal");
        i_led_ctrl_model.setBlank(1'h0);
        check(sinkOut, 16'h0000, "zero word");
    endtask
    // reset for 4 cycles, then the scenarios in turn
    initial begin
        repeat (4) @(posedge clkSys);
        #1;
        rst = 1'h0;
        chainAndDrive();
        statusRead();
        thermalRead();
        stopTest();
    end
endmodule // led_shift_latch_tb_top
